// ---- adcc_pkg.sv ----
/*
 converter control package: field widths, codes and timing counts.
 assumes a single 250 MHz system clock domain.
*/
package adcc_pkg;
   localparam int CLK_PERIOD_PS = 4000;
   localparam int SAMPLE_CYCLES = 4;
   localparam int CONVERT_CYCLES = 12;
   localparam logic [4:0] CONV_TOTAL = 5'h10;
   localparam logic [4:0] SAMPLE_LAST = 5'h03;
   localparam int CH_COUNT = 24;
   localparam logic [4:0] CH_LAST = 5'h17;
   localparam logic [1:0] REF_SUPPLY = 2'h1;
   localparam logic [2:0] INS_EXT = 3'h0;
   localparam logic [2:0] INS_BANDGAP = 3'h1;
   localparam logic [2:0] INS_RES_LO = 3'h2;
   localparam logic [2:0] INS_RES_HI = 3'h4;
   localparam logic [6:0] DIV_MAX = 7'h7F;
   localparam logic [1:0] MUX_FLOAT = 2'h0;
   localparam logic [1:0] MUX_EXT = 2'h1;
   localparam logic [1:0] MUX_BANDGAP = 2'h2;
   localparam logic [1:0] MUX_GROUND = 2'h3;
   typedef enum logic [1:0] {
      ADCC_IDLE = 2'b00,
      ADCC_ARMED = 2'b01,
      ADCC_BUSY = 2'b10
   } adcc_state_e;
endpackage

// ---- adcc_conversion_control.sv ----
/*
 converter control: start sequencing, busy flag, interrupt request,
 clock divider, power, reference and input selection, pin sharing.
 assumes control ports come from cpu logic on clk; resultIn is
 sampled from the analog core and needs no synchroniser.
*/
`timescale 1ns/10ps
`default_nettype none
// Operation
// - start needs low, high, low sequence
// - busy set on start, cleared on completion
// - completion sets request flag, interrupt if enabled
// - divider code n divides clock by 2^n
// - converter powered only while enable high
// - reference from supply only for code 01
// - analog pin disables other pin functions
// - analog pin drops pull-high resistor
// - analog pin overrides port direction
// - external channel routed for valid codes
// - codes 11000 upward leave input floating
// - code 001 selects bandgap signal
// - reserved codes 010 to 100 ground input
// - sample 4 then convert 12 clocks
module adcc_conversion_control
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control fields
   input wire logic startBit,
   input wire logic converterPowerEnable,
   input wire logic [2:0] clockDividerSelect,
   input wire logic [1:0] referenceSelect,
   input wire logic [2:0] internalInputSelect,
   input wire logic [4:0] externalChannelSelect,
   input wire logic intEnable,
   input wire logic intFlagClear,
   // pin sharing
   input wire logic [adcc_pkg::CH_COUNT-1:0] pinAnalogSel,
   input wire logic [adcc_pkg::CH_COUNT-1:0] pinPullHighReq,
   input wire logic [adcc_pkg::CH_COUNT-1:0] pinOutEnReq,
   input wire logic [adcc_pkg::CH_COUNT-1:0] pinAltFuncReq,
   // analog core
   input wire logic [11:0] resultIn,
   // status and result
   output logic conversionBusyFlag,
   output logic intRequestFlag,
   output logic intSignal,
   output logic [11:0] resultOut,
   // analog controls
   output logic converterPowerOn,
   output logic refFromSupply,
   output logic sampleActive,
   output logic converterClockEn,
   output logic [1:0] muxSource,
   output logic [adcc_pkg::CH_COUNT-1:0] channelConnect,
   // pin gating
   output logic [adcc_pkg::CH_COUNT-1:0] pinPullHighEn,
   output logic [adcc_pkg::CH_COUNT-1:0] pinOutEn,
   output logic [adcc_pkg::CH_COUNT-1:0] pinAltFuncEn
);
   import adcc_pkg::*;

   // ---------------------------------------------------------------
   // clock divider
   // ---------------------------------------------------------------
   function automatic logic [6:0] divMask(input logic [2:0] code);
      divMask = 7'(({7'h00, 1'b1} << code) - 8'h01);
   endfunction

   logic [6:0] divCnt_q, divCnt_d;
   logic tick;
   always_comb begin
      tick = ((divCnt_q & divMask(clockDividerSelect))
              == divMask(clockDividerSelect));
      divCnt_d = divCnt_q + 7'h01;
      if (!converterPowerEnable) begin
         divCnt_d = 7'h00;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         divCnt_q <= 7'h00;
      end else begin
         divCnt_q <= divCnt_d;
      end
   end

   // ---------------------------------------------------------------
   // start sequencing and busy
   // ---------------------------------------------------------------
   adcc_state_e state_q, state_d;
   logic [4:0] cnt_q, cnt_d;
   logic busy_q, busy_d;
   logic irq_q, irq_d;
   logic [11:0] res_q, res_d;
   logic done;
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      busy_d = busy_q;
      res_d = res_q;
      done = 1'b0;
      case (state_q)
         ADCC_IDLE: begin
            if (startBit) begin
               state_d = ADCC_ARMED;
            end
         end
         ADCC_ARMED: begin
            // a high start holds the converter reset
            if (!startBit && converterPowerEnable) begin
               state_d = ADCC_BUSY;
               busy_d = 1'b1;
               cnt_d = 5'h00;
            end
         end
         ADCC_BUSY: begin
            if (startBit) begin
               state_d = ADCC_ARMED;
               busy_d = 1'b0;
            end else if (!converterPowerEnable) begin
               // power loss aborts without interrupt
               state_d = ADCC_IDLE;
               busy_d = 1'b0;
            end else if (tick) begin
               cnt_d = cnt_q + 5'h01;
               if (cnt_q == CONV_TOTAL - 5'h01) begin
                  state_d = ADCC_IDLE;
                  busy_d = 1'b0;
                  res_d = resultIn;
                  done = 1'b1;
               end
            end
         end
         default: begin
            state_d = ADCC_IDLE;
         end
      endcase
      irq_d = irq_q;
      if (intFlagClear) begin
         irq_d = 1'b0;
      end
      if (done) begin
         irq_d = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ADCC_IDLE;
         cnt_q <= 5'h00;
         busy_q <= 1'b0;
         irq_q <= 1'b0;
         res_q <= 12'h000;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         irq_q <= irq_d;
         res_q <= res_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   logic [1:0] src;
   always_comb begin
      if (internalInputSelect == INS_BANDGAP) begin
         src = MUX_BANDGAP;
      end else if (internalInputSelect >= INS_RES_LO
                   && internalInputSelect <= INS_RES_HI) begin
         src = MUX_GROUND;
      end else if (externalChannelSelect <= CH_LAST) begin
         src = MUX_EXT;
      end else begin
         src = MUX_FLOAT;
      end
   end

   assign conversionBusyFlag = busy_q;
   assign intRequestFlag = irq_q;
   assign intSignal = irq_q & intEnable;
   assign resultOut = res_q;
   assign converterPowerOn = converterPowerEnable;
   assign refFromSupply = (referenceSelect == REF_SUPPLY);
   assign sampleActive = (state_q == ADCC_BUSY) && (cnt_q <= SAMPLE_LAST);
   assign converterClockEn = tick & converterPowerEnable;
   assign muxSource = src;
   assign channelConnect = (src == MUX_EXT)
      ? CH_COUNT'(({{(CH_COUNT-1){1'b0}}, 1'b1} << externalChannelSelect))
      : {CH_COUNT{1'b0}};
   assign pinPullHighEn = pinPullHighReq & ~pinAnalogSel;
   assign pinOutEn = pinOutEnReq & ~pinAnalogSel;
   assign pinAltFuncEn = pinAltFuncReq & ~pinAnalogSel;

   // ---------------------------------------------------------------
   // check helpers
   // ---------------------------------------------------------------
   // length of a run held wholly at the undivided clock; a counter
   // stands in for a long repetition that the tools would unroll
   logic startNow;
   logic fastRun_q, fastRun_d;
   logic [4:0] runCnt_q, runCnt_d;
   always_comb begin
      startNow = (state_q == ADCC_ARMED) && !startBit
                 && converterPowerEnable;
      runCnt_d = runCnt_q;
      fastRun_d = fastRun_q;
      if (startNow) begin
         runCnt_d = 5'h00;
         fastRun_d = (clockDividerSelect == 3'h0);
      end else if (busy_q) begin
         // saturate so a stuck busy cannot wrap back into range
         if (runCnt_q != 5'h1F) begin
            runCnt_d = runCnt_q + 5'h01;
         end
         if (clockDividerSelect != 3'h0 || startBit
             || !converterPowerEnable) begin
            fastRun_d = 1'b0;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         runCnt_q <= 5'h00;
         fastRun_q <= 1'b0;
      end else begin
         runCnt_q <= runCnt_d;
         fastRun_q <= fastRun_d;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_busy_on_start: assert property (@(posedge clk) disable iff (rst)
      state_q == ADCC_ARMED && !startBit && converterPowerEnable
      |=> conversionBusyFlag)
      else $error("busy not set after start pulse");
   a_busy_by_start: assert property (@(posedge clk) disable iff (rst)
      $rose(conversionBusyFlag)
      |-> $past(state_q) == ADCC_ARMED && $past(!startBit))
      else $error("busy rose without full start pulse");
   a_irq_on_done: assert property (@(posedge clk) disable iff (rst)
      $fell(conversionBusyFlag) && $past(done) |-> intRequestFlag)
      else $error("request flag not set at completion");
   a_int_gate: assert property (@(posedge clk) disable iff (rst)
      intSignal |-> intRequestFlag && intEnable)
      else $error("interrupt without flag and enable");
   a_div_tick: assert property (@(posedge clk) disable iff (rst)
      converterPowerEnable && $past(converterPowerEnable) && !$past(rst)
      && clockDividerSelect == 3'h1 && $stable(clockDividerSelect)
      |-> tick != $past(tick))
      else $error("divide by two tick wrong");
   a_power_follow: assert property (@(posedge clk) disable iff (rst)
      converterPowerOn == converterPowerEnable)
      else $error("power output mismatch");
   a_ref_sel: assert property (@(posedge clk) disable iff (rst)
      refFromSupply == (referenceSelect == 2'h1))
      else $error("reference select wrong");
   a_pin_gate: assert property (@(posedge clk) disable iff (rst)
      (pinPullHighEn & pinAnalogSel) == '0 && (pinOutEn & pinAnalogSel) == '0)
      else $error("analog pin keeps pull-high or drive");
   a_mux_bg: assert property (@(posedge clk) disable iff (rst)
      internalInputSelect == 3'h1 |-> muxSource == MUX_BANDGAP
      && channelConnect == '0)
      else $error("bandgap not selected");
   a_mux_float: assert property (@(posedge clk) disable iff (rst)
      internalInputSelect == 3'h0 && externalChannelSelect >= 5'h18
      |-> muxSource == MUX_FLOAT && channelConnect == '0)
      else $error("invalid channel not floating");
   a_fast_conv: assert property (@(posedge clk) disable iff (rst)
      done && fastRun_q && clockDividerSelect == 3'h0
      |-> runCnt_q == CONV_TOTAL - 5'h01)
      else $error("conversion not 16 clocks");
   a_fast_late: assert property (@(posedge clk) disable iff (rst)
      conversionBusyFlag && fastRun_q && clockDividerSelect == 3'h0
      |-> runCnt_q < CONV_TOTAL)
      else $error("conversion ran past 16 clocks");
   a_sample_busy: assert property (@(posedge clk) disable iff (rst)
      sampleActive |-> conversionBusyFlag)
      else $error("sampling outside a conversion");
   a_done_clears: assert property (@(posedge clk) disable iff (rst)
      done |=> !conversionBusyFlag)
      else $error("busy still set after completion");
   a_start_rearm: assert property (@(posedge clk) disable iff (rst)
      conversionBusyFlag && startBit |=> !conversionBusyFlag)
      else $error("high start did not hold converter reset");
   a_irq_set_wins: assert property (@(posedge clk) disable iff (rst)
      done && intFlagClear |=> intRequestFlag)
      else $error("clear beat completion on request flag");
   a_unpowered: assert property (@(posedge clk) disable iff (rst)
      !converterPowerEnable |-> !converterPowerOn && !converterClockEn)
      else $error("converter clocked while unpowered");
   a_mux_ext: assert property (@(posedge clk) disable iff (rst)
      (internalInputSelect == 3'h0 || internalInputSelect >= 3'h5)
      && externalChannelSelect <= 5'h17
      |-> muxSource == MUX_EXT
      && channelConnect == (24'h000001 << externalChannelSelect))
      else $error("external channel not routed");
   a_mux_ground: assert property (@(posedge clk) disable iff (rst)
      internalInputSelect >= 3'h2 && internalInputSelect <= 3'h4
      |-> muxSource == MUX_GROUND && channelConnect == '0)
      else $error("reserved input code not grounded");
   a_alt_gate: assert property (@(posedge clk) disable iff (rst)
      (pinAltFuncEn & pinAnalogSel) == '0)
      else $error("analog pin keeps another function");
   a_result_upd: assert property (@(posedge clk) disable iff (rst)
      done |=> resultOut == $past(resultIn))
      else $error("result not updated at busy clear");
   c_conv_done: cover property (@(posedge clk) disable iff (rst) done);
   c_irq_int: cover property (@(posedge clk) disable iff (rst) intSignal);
   c_bandgap: cover property (@(posedge clk) disable iff (rst)
      muxSource == MUX_BANDGAP && conversionBusyFlag);
   c_ground: cover property (@(posedge clk) disable iff (rst)
      muxSource == MUX_GROUND);
   c_restart: cover property (@(posedge clk) disable iff (rst)
      conversionBusyFlag && startBit);
endmodule
`default_nettype wire

// ---- tb_adcc_conversion_control.sv ----
/*
 self-checking bench for the converter control block.
 assumes adcc_pkg and adcc_conversion_control are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(act, exp) begin \
   samplesChecked++; \
   if ((act) !== (exp)) begin \
      miscompares++; \
      $display("[ERR] t=%0t got %h exp %h", $time, act, exp); \
   end \
end
module tb_adcc_conversion_control;
   import adcc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, startBit = 1'b0, powerEn = 1'b0;
   logic [2:0] divSel = 3'h0, insSel = 3'h0;
   logic [1:0] refSel = 2'h0;
   logic [4:0] extSel = 5'h00;
   logic intEnable = 1'b0, intFlagClear = 1'b0;
   logic [23:0] anaSel = 24'h0, pullReq = 24'h0;
   logic [23:0] oeReq = 24'h0, altReq = 24'h0;
   logic [11:0] resultIn = 12'h000, resultOut;
   logic busy, irq, intSignal, powerOn, refSup, sampleActive, clkEn;
   logic [1:0] muxSource;
   logic [23:0] chanConn, pullEn, oeEn, altEn;
   int miscompares = 0;
   int samplesChecked = 0;
   // settling wait after power up; a plain default, not a device figure
   localparam int SETTLE_CYCLES = 8;
   adcc_conversion_control u_dut (.clk(clk), .rst(rst), .startBit(startBit),
      .converterPowerEnable(powerEn), .clockDividerSelect(divSel),
      .referenceSelect(refSel), .internalInputSelect(insSel),
      .externalChannelSelect(extSel), .intEnable(intEnable),
      .intFlagClear(intFlagClear), .pinAnalogSel(anaSel),
      .pinPullHighReq(pullReq), .pinOutEnReq(oeReq), .pinAltFuncReq(altReq),
      .resultIn(resultIn), .conversionBusyFlag(busy), .intRequestFlag(irq),
      .intSignal(intSignal), .resultOut(resultOut), .converterPowerOn(powerOn),
      .refFromSupply(refSup), .sampleActive(sampleActive),
      .converterClockEn(clkEn), .muxSource(muxSource),
      .channelConnect(chanConn), .pinPullHighEn(pullEn), .pinOutEn(oeEn),
      .pinAltFuncEn(altEn));
   always #2 clk = ~clk;
   task automatic testDone;
      if (miscompares == 0 && samplesChecked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic startPulse;
      startBit = 1'b1;
      @(negedge clk);
      startBit = 1'b0;
      @(negedge clk);
   endtask
   // counts busy cycles; bounded so a stuck flag cannot hang the run
   task automatic runConv(output int len, output int samp);
      len = 0;
      samp = 0;
      while (busy === 1'b1 && len < 5000) begin
         len++;
         if (sampleActive === 1'b1) samp++;
         @(negedge clk);
      end
   endtask
   task automatic clearIrq;
      intFlagClear = 1'b1;
      @(negedge clk);
      intFlagClear = 1'b0;
      @(negedge clk);
   endtask
   task automatic testBasic;
      int len, samp;
      intEnable = 1'b1;
      resultIn = 12'hA5C;
      startPulse();
      `CHK(busy, 1'b1)
      runConv(len, samp);
      `CHK(len, 16)
      `CHK(samp, 4)
      `CHK(resultOut, 12'hA5C)
      `CHK(irq, 1'b1)
      `CHK(intSignal, 1'b1)
      intEnable = 1'b0;
      @(negedge clk);
      `CHK(intSignal, 1'b0)
      clearIrq();
      `CHK(irq, 1'b0)
   endtask
   task automatic testDivider;
      int cnt, len, samp;
      // only code 111 meets the minimum converter period at this clock;
      // faster codes here exercise the logic timing only
      for (int n = 0; n < 8; n++) begin
         divSel = n[2:0];
         resultIn = {4'h3, n[7:0]};
         @(negedge clk);
         cnt = 0;
         repeat (256) begin
            if (clkEn === 1'b1) cnt++;
            @(negedge clk);
         end
         `CHK(cnt, 256 >> n)
         startPulse();
         runConv(len, samp);
         `CHK((len > (15 << n)) && (len <= (16 << n) + 1), 1'b1)
         `CHK(resultOut, resultIn)
         clearIrq();
      end
      divSel = 3'h0;
   endtask
   task automatic testPower;
      int len, samp;
      powerEn = 1'b0;
      @(negedge clk);
      `CHK(powerOn, 1'b0)
      startPulse();
      `CHK(busy, 1'b0)
      powerEn = 1'b1;
      @(negedge clk);
      `CHK(busy, 1'b1)
      repeat (5) @(negedge clk);
      powerEn = 1'b0;
      @(negedge clk);
      `CHK(busy, 1'b0)
      `CHK(irq, 1'b0)
      powerEn = 1'b1;
      repeat (SETTLE_CYCLES) @(negedge clk);
   endtask
   task automatic testReset;
      int len, samp;
      resultIn = 12'h5A5;
      startPulse();
      repeat (2) @(negedge clk);
      startBit = 1'b1;
      @(negedge clk);
      `CHK(busy, 1'b0)
      startBit = 1'b0;
      @(negedge clk);
      `CHK(busy, 1'b1)
      repeat (2) @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      `CHK(busy, 1'b0)
      `CHK(resultOut, 12'h000)
      // clear held through completion: the set must win
      intFlagClear = 1'b1;
      startPulse();
      runConv(len, samp);
      `CHK(len, 16)
      `CHK(irq, 1'b1)
      `CHK(resultOut, 12'h5A5)
      intFlagClear = 1'b0;
      clearIrq();
      `CHK(irq, 1'b0)
   endtask
   task automatic testMux;
      logic [1:0] m;
      for (int i = 0; i < 8; i++) begin
         for (int e = 0; e < 32; e++) begin
            insSel = i[2:0];
            extSel = (i == 1) ? (e[4:0] | 5'h18) : e[4:0];
            if (i == 1) m = MUX_BANDGAP;
            else if (i >= 2 && i <= 4) m = MUX_GROUND;
            else m = (e < 24) ? MUX_EXT : MUX_FLOAT;
            @(negedge clk);
            `CHK(muxSource, m)
            `CHK(chanConn, (m == MUX_EXT) ? (24'h000001 << e) : 24'h0)
         end
      end
      // reference pin function stays unconfigured here
      for (int r = 0; r < 4; r++) begin
         refSel = r[1:0];
         @(negedge clk);
         `CHK(refSup, r == 1)
      end
   endtask
   task automatic testPins;
      anaSel = 24'hC3A55A;
      pullReq = 24'hFFFFFF;
      oeReq = 24'hF0F0F0;
      altReq = 24'h0FF00F;
      @(negedge clk);
      `CHK(pullEn, 24'h3C5AA5)
      `CHK(oeEn, 24'h3050A0)
      `CHK(altEn, 24'h0C5005)
      `CHK(powerOn, 1'b0)
      `CHK(clkEn, 1'b0)
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      `CHK(busy, 1'b0)
      `CHK(irq, 1'b0)
      `CHK(resultOut, 12'h000)
      powerEn = 1'b1;
      repeat (SETTLE_CYCLES) @(negedge clk);
      testBasic();
      testDivider();
      testPower();
      testReset();
      powerEn = 1'b0;
      testMux();
      testPins();
      testDone();
   end
   // watchdog well past the longest expected run
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      testDone();
   end
endmodule
`default_nettype wire
